// ==== rtl/block_averager.sv ====
// Block averager: accumulates a set of samples and emits their mean
`timescale 1ns/1ps
`default_nettype none
module block_averager
	import temp_regs_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clear,
	input  wire logic [1:0]  i_avg_sel,
	input  wire sample_s     i_sample,
	output sample_s          o_mean
);

	logic [6:0]  count_q;
	logic [6:0]  count_d;
	logic [22:0] acc_q;
	logic [22:0] acc_d;
	logic [22:0] acc_sum;
	logic [22:0] acc_shift;
	logic [6:0]  target;
	logic [2:0]  shift;
	logic        last;

	assign target = (i_avg_sel == AVG_1) ? CNT_1 :
			(i_avg_sel == AVG_8) ? CNT_8 :
			(i_avg_sel == AVG_32) ? CNT_32 : CNT_64;
	assign shift = (i_avg_sel == AVG_1) ? SHIFT_1 :
			(i_avg_sel == AVG_8) ? SHIFT_8 :
			(i_avg_sel == AVG_32) ? SHIFT_32 : SHIFT_64;
	assign acc_sum = acc_q + {{7{i_sample.code[15]}}, i_sample.code};
	assign acc_shift = $signed(acc_sum) >>> shift;
	assign last = i_sample.valid && ((count_q + 7'h01) == target);
	// Block mean, accumulator restarts after each result
	assign acc_d = (i_clear || last) ? 23'h00_0000 :
			(i_sample.valid ? acc_sum : acc_q);
	assign count_d = (i_clear || last) ? 7'h00 :
			(i_sample.valid ? count_q + 7'h01 : count_q);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			acc_q <= 23'h00_0000;
			count_q <= 7'h00;
			o_mean <= '0;
		end
		else
		begin
			acc_q <= acc_d;
			count_q <= count_d;
			o_mean.valid <= last && !i_clear;
			if (last)
				o_mean.code <= acc_shift[15:0];
		end
	end

endmodule // block_averager
`default_nettype wire

// ==== rtl/temp_regs_pkg.sv ====
// Package: register map, field layout and timing constants of the sensor register bank
package temp_regs_pkg;

	// ****************************************
	// Register addresses and reset values
	// ****************************************
	localparam logic [7:0]  ADDR_RESULT   = 8'h00;
	localparam logic [7:0]  ADDR_CONFIG   = 8'h01;
	localparam logic [15:0] RESULT_RESET  = 16'h8000;
	localparam logic [15:0] CONFIG_RESET  = 16'h0220;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;

	// ****************************************
	// Configuration field positions
	// ****************************************
	localparam int BIT_HIGH_FLAG = 15;
	localparam int BIT_LOW_FLAG  = 14;
	localparam int BIT_DONE_FLAG = 13;
	localparam int BIT_NV_BUSY   = 12;
	localparam int MODE_HI       = 11;
	localparam int MODE_LO       = 10;
	localparam int CYCLE_HI      = 9;
	localparam int CYCLE_LO      = 7;
	localparam int AVG_HI        = 6;
	localparam int AVG_LO        = 5;
	localparam int BIT_THERM_SEL = 4;
	localparam int BIT_POLARITY  = 3;
	localparam int BIT_PIN_SRC   = 2;
	localparam int BIT_SOFT_RST  = 1;

	// ****************************************
	// Mode and averaging codes
	// ****************************************
	localparam logic [1:0] MODE_CONT     = 2'h0;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
	localparam logic [1:0] MODE_CONT_ALT = 2'h2;
	localparam logic [1:0] MODE_SINGLE   = 2'h3;
	localparam logic [1:0] AVG_1         = 2'h0;
	localparam logic [1:0] AVG_8         = 2'h1;
	localparam logic [1:0] AVG_32        = 2'h2;
	localparam logic [1:0] AVG_64        = 2'h3;
	localparam logic [6:0] CNT_1         = 7'h01;
	localparam logic [6:0] CNT_8         = 7'h08;
	localparam logic [6:0] CNT_32        = 7'h20;
	localparam logic [6:0] CNT_64        = 7'h40;
	localparam logic [2:0] SHIFT_1       = 3'h0;
	localparam logic [2:0] SHIFT_8       = 3'h3;
	localparam logic [2:0] SHIFT_32      = 3'h5;
	localparam logic [2:0] SHIFT_64      = 3'h6;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ        = 10_000_000;
	localparam int SOFT_RST_US   = 2000;
	localparam int SOFT_RST_CYC  = SOFT_RST_US * (CLK_HZ / 1_000_000);

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] cycle;
		logic [1:0] avg;
		logic       therm_or_window_sel;
		logic       alarm_pin_polarity;
		logic       alarm_pin_source_sel;
	} cfg_fields_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] code;
	} sample_s;

endpackage

// ==== rtl/temp_sensor_result_config_regs.sv ====
// Result and configuration register bank of a digital temperature sensor
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 16-bit read-only result holds latest completed conversion; writes ignored.
// - One result LSB equals 7.8125 millidegrees Celsius.
// - Result is signed two's complement; negative temperatures set the MSB.
// - After reset result reads 8000h until first full averaged conversion stored.
// - Result at address 00h, configuration at 01h, configuration resets to 0220h.
// - Mode 00/10 continuous (10 reads 00), 01 shutdown, 11 single conversion.
// - Done flag sets on result update; clears on result or configuration read.
// - Averaging 1, 8, 32 or 64 conversions; stored result is a block average.
// - Writing one to soft reset starts about 2 ms reset; bit reads zero.
module temp_sensor_result_config_regs
	import temp_regs_pkg::*;
#(
	parameter int SOFT_RST_CYCLES = SOFT_RST_CYC
)
(
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [15:0] i_reg_wdata,
	input  wire logic        i_conv_valid,
	input  wire logic [15:0] i_conv_code,
	input  wire logic        i_high_flag,
	input  wire logic        i_low_flag,
	input  wire logic        i_nv_busy,
	output logic [15:0]      o_reg_rdata,
	output logic             o_conv_run,
	output logic             o_soft_rst_busy,
	output cfg_fields_s      o_cfg
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SINGLE} conv_state_e;

	conv_state_e state_q;
	conv_state_e state_d;
	cfg_fields_s cfg_q;
	cfg_fields_s cfg_d;
	logic [15:0] result_q;
	logic        done_q;
	logic        done_d;
	logic [14:0] srst_cnt_q;
	logic [14:0] srst_cnt_d;
	sample_s     sample_in;
	sample_s     mean;
	logic        hit_result;
	logic        hit_config;
	logic        cfg_write;
	logic        cfg_read_clr;
	logic        srst_start;
	logic        srst_busy;
	logic        local_rst;
	logic [1:0]  mode_wr;
	logic [15:0] cfg_view;

	// ****************************************
	// Decode
	// ****************************************
	// address decode
	assign hit_result = (i_reg_addr == ADDR_RESULT);
	assign hit_config = (i_reg_addr == ADDR_CONFIG);
	assign srst_busy = (srst_cnt_q != 15'h0000);
	assign srst_start = i_reg_wr && hit_config && i_reg_wdata[BIT_SOFT_RST] && !srst_busy;
	assign cfg_write = i_reg_wr && hit_config && !srst_start && !srst_busy;
	assign cfg_read_clr = i_reg_rd && (hit_result || hit_config);
	assign local_rst = srst_start || srst_busy;
	assign mode_wr = (i_reg_wdata[MODE_HI:MODE_LO] == MODE_CONT_ALT) ?
			MODE_CONT : i_reg_wdata[MODE_HI:MODE_LO];

	always_comb
	begin
		cfg_d = cfg_q;
		if (local_rst)
			cfg_d = CONFIG_RESET[MODE_HI:BIT_PIN_SRC];
		else if (cfg_write)
		begin
			cfg_d.mode = mode_wr;
			cfg_d.cycle = i_reg_wdata[CYCLE_HI:CYCLE_LO];
			cfg_d.avg = i_reg_wdata[AVG_HI:AVG_LO];
			cfg_d.therm_or_window_sel = i_reg_wdata[BIT_THERM_SEL];
			cfg_d.alarm_pin_polarity = i_reg_wdata[BIT_POLARITY];
			cfg_d.alarm_pin_source_sel = i_reg_wdata[BIT_PIN_SRC];
		end
		else if (state_q == ST_SINGLE && mean.valid)
			cfg_d.mode = MODE_SHUTDOWN;
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************
	// mode selects sequencing
	always_comb
	begin
		state_d = state_q;
		case (cfg_d.mode)
			MODE_SHUTDOWN: state_d = ST_IDLE;
			MODE_SINGLE:   state_d = ST_SINGLE;
			MODE_CONT:     state_d = ST_RUN;
			default:       state_d = ST_RUN;
		endcase
	end

	assign o_conv_run = (state_q != ST_IDLE) && !srst_busy;
	assign sample_in.valid = i_conv_valid && o_conv_run;
	assign sample_in.code = i_conv_code;

	block_averager u_avg (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clear   (local_rst || cfg_write),
		.i_avg_sel (cfg_q.avg),
		.i_sample  (sample_in),
		.o_mean    (mean)
	);

	// done flag, set wins over read clear, soft reset wins over both
	assign done_d = local_rst ? 1'b0 : (mean.valid ? 1'b1 : (cfg_read_clr ? 1'b0 : done_q));
	assign srst_cnt_d = srst_start ? SOFT_RST_CYCLES[14:0] :
			(srst_busy ? srst_cnt_q - 15'h0001 : srst_cnt_q);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			result_q <= RESULT_RESET;
			cfg_q <= CONFIG_RESET[MODE_HI:BIT_PIN_SRC];
			done_q <= 1'b0;
			srst_cnt_q <= 15'h0000;
			state_q <= ST_RUN;
		end
		else
		begin
			if (local_rst)
				result_q <= RESULT_RESET;
			else if (mean.valid)
				result_q <= mean.code;
			cfg_q <= cfg_d;
			done_q <= done_d;
			srst_cnt_q <= srst_cnt_d;
			state_q <= state_d;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// configuration layout, soft reset reads zero
	assign cfg_view = {i_high_flag, i_low_flag, done_q, i_nv_busy, cfg_q, 2'b00};
	// code passed raw as signed steps
	assign o_reg_rdata = hit_result ? result_q : (hit_config ? cfg_view : UNMAPPED_READ);
	assign o_soft_rst_busy = srst_busy;
	assign o_cfg = cfg_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_write_no_result;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_wr && hit_result && !mean.valid && !local_rst) |=> $stable(result_q);
	endproperty
	a_write_no_result: assert property (p_write_no_result)
		else $error("Result changed by write");

	property p_update;
		@(posedge i_clk) disable iff (i_sys_rst)
		(mean.valid && !local_rst) |=> (result_q == $past(mean.code)) && done_q;
	endproperty
	a_update: assert property (p_update)
		else $error("Result or done not updated");

	property p_sentinel;
		@(posedge i_clk) disable iff (i_sys_rst)
		srst_start |=> (result_q == RESULT_RESET) && (cfg_q == CONFIG_RESET[MODE_HI:BIT_PIN_SRC]);
	endproperty
	a_sentinel: assert property (p_sentinel)
		else $error("Reset values not restored");

	property p_map;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_addr == ADDR_CONFIG) |-> (o_reg_rdata[BIT_SOFT_RST] == 1'b0)
			&& (o_reg_rdata[BIT_DONE_FLAG] == done_q);
	endproperty
	a_map: assert property (p_map)
		else $error("Configuration layout wrong");

	property p_mode_fold;
		@(posedge i_clk) disable iff (i_sys_rst)
		(cfg_write && i_reg_wdata[MODE_HI:MODE_LO] == MODE_CONT_ALT) |=> (cfg_q.mode == MODE_CONT);
	endproperty
	a_mode_fold: assert property (p_mode_fold)
		else $error("Mode 10 not folded");

	property p_shutdown;
		@(posedge i_clk) disable iff (i_sys_rst)
		(cfg_q.mode == MODE_SHUTDOWN) [*2] |-> !o_conv_run;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("Conversion running in shutdown");

	property p_read_clear;
		@(posedge i_clk) disable iff (i_sys_rst)
		(cfg_read_clr && !mean.valid) |=> !done_q;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("Done not cleared on read");

	sequence s_srst_req;
		srst_start;
	endsequence
	sequence s_srst_hold;
		o_soft_rst_busy [*8];
	endsequence
	property p_srst;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_srst_req |=> s_srst_hold;
	endproperty
	a_srst: assert property (p_srst)
		else $error("Soft reset too short");

	property p_addr;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_reg_addr == ADDR_RESULT) |-> (o_reg_rdata == result_q);
	endproperty
	a_addr: assert property (p_addr)
		else $error("Result not at its address");

endmodule // temp_sensor_result_config_regs
`default_nettype wire

// ==== verification/host_model.sv ====
// Host model: register bus master that strobes one word per transfer
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic        i_clk,
	output logic [7:0]       o_addr,
	output logic             o_wr,
	output logic             o_rd,
	output logic [15:0]      o_wdata
);
	// ****************************************
	// Idle levels
	// ****************************************
	initial
	begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'h0000;
	end

	// ****************************************
	// One strobe cycle, then an idle cycle
	// ****************************************
	// Released data is inverted so a stale word never looks valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge i_clk);
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = ~d;
	endtask
endmodule // host_model
`default_nettype wire

// ==== verification/temp_sensor_result_config_regs_test.sv ====
// Testbench: register bank reset, averaging, modes and soft reset
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_result_config_regs_test
	import temp_regs_pkg::*;
;
	localparam int SRST = 16;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr;
	logic        wr, rd, run, busy;
	logic [15:0] wdata, rdata, exp_code;
	logic        cv = 1'b0;
	logic [15:0] cc = 16'h0000;
	logic        hf = 1'b0;
	logic        lf = 1'b0;
	logic        nb = 1'b0;
	logic [31:0] seed = 32'h0001_3EBF;
	cfg_fields_s cfg;
	logic [15:0] exp_q[$];
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n_tab[4] = '{1, 8, 32, 64};
	int          sh_tab[4] = '{0, 3, 5, 6};

	always #50 clk = ~clk;

	host_model i_host_model (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

	temp_sensor_result_config_regs #(.SOFT_RST_CYCLES(SRST)) i_temp_sensor_result_config_regs (
		.i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_wdata(wdata), .i_conv_valid(cv), .i_conv_code(cc), .i_high_flag(hf),
		.i_low_flag(lf), .i_nv_busy(nb), .o_reg_rdata(rdata), .o_conv_run(run),
		.o_soft_rst_busy(busy), .o_cfg(cfg));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic results;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic rd_x(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		i_host_model.xfer(1'b0, a, 16'h0000);
	endtask

	task automatic wr_x(input logic [7:0] a, input logic [15:0] d);
		i_host_model.xfer(1'b1, a, d);
	endtask

	// Block mean is floor(sum/N), so an arithmetic shift of the signed sum
	task automatic samp(input int n, input int sh);
		int s;
		s = 0;
		repeat (n)
		begin
			seed = lfsr(seed);
			@(negedge clk);
			cv = 1'b1;
			cc = seed[15:0];
			s = s + int'($signed(seed[15:0]));
			@(negedge clk);
			cv = 1'b0;
		end
		exp_code = 16'(s >>> sh);
	endtask

	// ****************************************
	// Read data watcher
	// ****************************************
	always @(posedge clk)
		if (rd === 1'b1)
			chk(rdata, exp_q.pop_front());

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rd_x(ADDR_RESULT, RESULT_RESET);
		rd_x(ADDR_CONFIG, CONFIG_RESET);
		rd_x(8'h05, UNMAPPED_READ);
		wr_x(ADDR_RESULT, 16'h1234);
		rd_x(ADDR_RESULT, RESULT_RESET);
		for (int k = 0; k < 4; k++)
		begin
			wr_x(ADDR_CONFIG, 16'h0200 | 16'(k << 5));
			samp(n_tab[k], sh_tab[k]);
			rd_x(ADDR_CONFIG, 16'h2200 | 16'(k << 5));
			rd_x(ADDR_RESULT, exp_code);
			rd_x(ADDR_CONFIG, 16'h0200 | 16'(k << 5));
		end
		wr_x(ADDR_CONFIG, 16'h0A3C);
		rd_x(ADDR_CONFIG, 16'h023C);
		chk({6'h00, cfg}, 16'h008F);
		// Status levels land in the top nibble
		{hf, lf, nb} = 3'b101;
		rd_x(ADDR_CONFIG, 16'h923C);
		{hf, lf, nb} = 3'b010;
		rd_x(ADDR_CONFIG, 16'h423C);
		{hf, lf, nb} = 3'b000;
		wr_x(ADDR_CONFIG, 16'h0620);
		chk({15'h0000, run}, 16'h0000);
		// Single conversion falls back to shutdown once stored
		wr_x(ADDR_CONFIG, 16'h0E00);
		chk({15'h0000, run}, 16'h0001);
		samp(1, 0);
		rd_x(ADDR_CONFIG, 16'h2600);
		rd_x(ADDR_RESULT, exp_code);
		wr_x(ADDR_CONFIG, 16'h0062);
		chk({15'h0000, busy}, 16'h0001);
		rd_x(ADDR_RESULT, RESULT_RESET);
		rd_x(ADDR_CONFIG, CONFIG_RESET);
		wr_x(ADDR_CONFIG, 16'h0000);
		for (int i = 0; i < SRST + 4 && busy !== 1'b0; i++)
			@(negedge clk);
		chk({15'h0000, busy}, 16'h0000);
		rd_x(ADDR_CONFIG, CONFIG_RESET);
		// One raw sample of minus 25 degrees, code is temperature over the step
		wr_x(ADDR_CONFIG, 16'h0000);
		@(negedge clk);
		cv = 1'b1;
		cc = 16'(-25000 * 10000 / 78125);
		@(negedge clk);
		cv = 1'b0;
		rd_x(ADDR_RESULT, 16'hF380);
		// Hardware reset in mid-run brings the sentinel back
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd_x(ADDR_RESULT, RESULT_RESET);
		rd_x(ADDR_CONFIG, CONFIG_RESET);
		@(negedge clk);
		results();
	end

	// ****************************************
	// Watchdog
	// ****************************************
	initial
	begin
		#(3000 * 100);
		n_mismatch++;
		results();
	end
endmodule // temp_sensor_result_config_regs_test
`default_nettype wire
